// *** shared/mos_pkg.sv ***
// Constants and types shared by the motor output source mux.
package mos_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_STEP_OUTPUT_SOURCE_SELECT = 8'h2D;
  localparam logic [7:0] OFS_ANALOG_OUT0_DIRECT_VALUE = 8'h90;
  localparam logic [7:0] OFS_ANALOG_OUT1_DIRECT_VALUE = 8'h91;
  localparam logic [7:0] OFS_ANALOG_OUT2_DIRECT_VALUE = 8'h92;
  localparam logic [7:0] OFS_CURRENT_LEVEL_DIRECT_VALUE = 8'h93;
  localparam logic [7:0] OFS_OUTPUT_SOURCE_CONFIG = 8'h94;
  localparam logic [7:0] OFS_TABLE_WRITE_ADDRESS = 8'hE0;
  localparam logic [7:0] OFS_TABLE_WRITE_DATA = 8'hE1;
  localparam logic [7:0] OFS_TABLE_END = 8'hE4;
  localparam logic [7:0] OFS_TABLE_POINTER_PHASE_A = 8'hE5;
  localparam logic [7:0] OFS_TABLE_POINTER_PHASE_B = 8'hE6;
  localparam logic [7:0] OFS_TABLE_POINTER_PHASE_C = 8'hE7;

  // Widths and sizes.
  localparam int PHASE_COUNT = 3;
  localparam int POINTER_WIDTH = 7;
  localparam int TABLE_DEPTH = 128;
  localparam int VELOCITY_WIDTH = 24;
  localparam int STEP_BUS_WIDTH = 10;

  // Slice positions of the velocity and the table word.
  localparam int VEL_ANALOG_MSB = 12;
  localparam int VEL_ANALOG_LSB = 5;
  localparam int VEL_STEP_MSB = 12;
  localparam int VEL_STEP_LSB = 3;
  localparam int WORD_LOW_LSB = 0;
  localparam int WORD_MID_LSB = 8;
  localparam int WORD_HIGH_LSB = 14;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_TWO_BITS = 2'h0;
  localparam logic [6:0] RST_POINTER = 7'h00;
  localparam logic [6:0] RST_TABLE_END = 7'h7F;

  typedef enum logic [1:0] {
    STO_SEQUENCER = 2'h0,
    STO_TABLE_LOW = 2'h1,
    STO_TABLE_MID = 2'h2,
    STO_TABLE_HIGH = 2'h3
  } mos_sto_sel_type;

  typedef struct packed {
    logic velocityToStepOutputs;
    logic velocityToAnalog2;
    logic currentLevelDirectSelect;
    logic analog2DirectSelect;
    logic analog1DirectSelect;
    logic analog0DirectSelect;
  } mos_conf_type;

  // Generator inputs that feed the mux.
  typedef struct packed {
    logic sinestepActive;
    logic microstepActive;
    logic threePhaseMotor;
    logic [7:0] cosineWave;
    logic [7:0] sineWave;
    logic [7:0] currentControlLevel;
    logic [1:0] currentControlBits;
    logic [9:0] sequencerSteps;
  } mos_source_type;

endpackage

// *** design/mos_phase_pointer.sv ***
// One microstep table pointer that walks with every step.
`timescale 1ns/100ps
module mos_phase_pointer (
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Software load.
  input wire logic loadEnable,
  input wire logic [6:0] loadValue,
  // Step events.
  input wire logic stepPulse,
  input wire logic stepForward,
  input wire logic [6:0] tableEnd,
  // Pointer value.
  output logic [6:0] pointer
);

  logic [6:0] pointer_ff;
  logic [6:0] nxt_pointer;

  always_comb begin
    nxt_pointer = pointer_ff;
    if (loadEnable) begin
      nxt_pointer = loadValue;
    end else if (stepPulse) begin
      // The pointer wraps with a modulus of table end plus one.
      if (stepForward) begin
        nxt_pointer = (pointer_ff >= tableEnd) ? mos_pkg::RST_POINTER
                                               : pointer_ff + 7'h01;
      end else begin
        nxt_pointer = (pointer_ff == mos_pkg::RST_POINTER) ? tableEnd
                                                           : pointer_ff - 7'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pointer_ff <= mos_pkg::RST_POINTER;
    end else begin
      pointer_ff <= nxt_pointer;
    end
  end

  assign pointer = pointer_ff;

endmodule

// *** design/mos_velocity_format.sv ***
// Velocity slices for the analog channel and the step output bus.
`timescale 1ns/100ps
module mos_velocity_format (
  // Actual velocity, two's complement.
  input wire logic [23:0] velocity,
  // Formatted values.
  output logic [7:0] analogLevel,
  output logic [9:0] stepWord
);

  logic [23:0] magnitude;

  // The analog channel cannot show a sign, so it gets the magnitude.
  assign magnitude = velocity[mos_pkg::VELOCITY_WIDTH-1] ? 24'(-velocity)
                                                         : velocity;
  assign analogLevel =
    magnitude[mos_pkg::VEL_ANALOG_MSB:mos_pkg::VEL_ANALOG_LSB];
  // The step bus keeps the sign as a 10-bit signed integer.
  assign stepWord = velocity[mos_pkg::VEL_STEP_MSB:mos_pkg::VEL_STEP_LSB];

endmodule

// *** design/mos_output_mux.sv ***
// Output source mux for analog channels, current level and step outputs.
`timescale 1ns/100ps
// Functional notes
// - Each analog channel has its own 8-bit direct register for direct mode.
// - A 2-bit direct register sets both current-level pins in direct mode.
// - Channel 0: cosine in sinestep, phase-0 byte in microstep, else select.
// - Channel 1: sine in sinestep, phase-1 byte in microstep, else select.
// - Channel 2: phase-2 byte in three-phase microstep, else its select.
// - Velocity-to-analog2 drives channel 2 with the absolute velocity.
// - The analog velocity is velocity magnitude bits 12 down to 5.
// - Current-level select 0 takes current control, 1 the direct register.
// - Velocity-to-step-outputs drives the step bus with velocity bits 12-3.
// - The velocity on the step bus is 10-bit signed and beats the select.
// - Codes 01, 10, 11 put word bits 9-0, 17-8, 23-14 on the step bus.
// - Select code 00 puts the step sequencer on the step bus.
// - The three table bytes at the phase pointers form one 24-bit word.
// - Each pointer addresses one table byte and moves one place per step.
module mos_output_mux (
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Generators.
  input wire mos_pkg::mos_source_type sources,
  input wire logic [23:0] actualVelocity,
  input wire logic stepPulse,
  input wire logic stepForward,
  // Converter inputs and pins.
  output logic [7:0] analogOutZero,
  output logic [7:0] analogOutOne,
  output logic [7:0] analogOutTwo,
  output logic currentLevelLowPin,
  output logic currentLevelHighPin,
  output logic [9:0] stepOutputBus
);

  typedef struct packed {
    logic [1:0] stepSourceSelect;
    logic [7:0] analog0DirectLevel;
    logic [7:0] analog1DirectLevel;
    logic [7:0] analog2DirectLevel;
    logic [1:0] currentLevelDirectBits;
    mos_pkg::mos_conf_type conf;
    logic [6:0] tableWriteAddress;
    logic [6:0] tableEnd;
    logic [7:0] readData;
    logic [7:0] analog0;
    logic [7:0] analog1;
    logic [7:0] analog2;
    logic [1:0] currentLevel;
    logic [9:0] stepBus;
  } mos_state_type;

  mos_state_type s_ff;
  mos_state_type nxt_s;
  logic [7:0] tableRam [mos_pkg::TABLE_DEPTH];
  logic [6:0] tablePointer [mos_pkg::PHASE_COUNT];
  logic [7:0] tableByte [mos_pkg::PHASE_COUNT];
  logic [23:0] tableWord;
  logic [7:0] velocityLevel;
  logic [9:0] velocityStep;
  logic tableWrite;

  // Index of the phase pointer at an address, or PHASE_COUNT if none.
  function automatic logic [1:0] pointerIndex(input logic [7:0] addr);
    logic [1:0] idx;
    idx = 2'(mos_pkg::PHASE_COUNT);
    if (addr == mos_pkg::OFS_TABLE_POINTER_PHASE_A) begin
      idx = 2'h0;
    end else if (addr == mos_pkg::OFS_TABLE_POINTER_PHASE_B) begin
      idx = 2'h1;
    end else if (addr == mos_pkg::OFS_TABLE_POINTER_PHASE_C) begin
      idx = 2'h2;
    end
    return idx;
  endfunction

  // Step bus slice of the table word for a select code.
  function automatic logic [9:0] wordSlice(input logic [23:0] word,
                                          input logic [1:0] sel);
    logic [9:0] slice;
    slice = word[mos_pkg::WORD_LOW_LSB +: mos_pkg::STEP_BUS_WIDTH];
    if (sel == mos_pkg::STO_TABLE_MID) begin
      slice = word[mos_pkg::WORD_MID_LSB +: mos_pkg::STEP_BUS_WIDTH];
    end else if (sel == mos_pkg::STO_TABLE_HIGH) begin
      slice = word[mos_pkg::WORD_HIGH_LSB +: mos_pkg::STEP_BUS_WIDTH];
    end
    return slice;
  endfunction

  genvar g;
  generate
    for (g = 0; g < mos_pkg::PHASE_COUNT; g++) begin : gPhase
      mos_phase_pointer uPointer (
        .clock(clock),
        .arst_n(arst_n),
        .loadEnable(regWr && (pointerIndex(regAddr) == 2'(g))),
        .loadValue(regWrData[6:0]),
        .stepPulse(stepPulse),
        .stepForward(stepForward),
        .tableEnd(s_ff.tableEnd),
        .pointer(tablePointer[g])
      );
      assign tableByte[g] = tableRam[tablePointer[g]];
    end
  endgenerate

  // Phase 0 sits in the low byte so code 01 starts at its first bit.
  assign tableWord = {tableByte[2], tableByte[1], tableByte[0]};

  mos_velocity_format uVelocity (
    .velocity(actualVelocity),
    .analogLevel(velocityLevel),
    .stepWord(velocityStep)
  );

  assign tableWrite = regWr && (regAddr == mos_pkg::OFS_TABLE_WRITE_DATA);

  // The table is plain memory, so it carries no reset.
  always_ff @(posedge clock) begin
    if (tableWrite) begin
      tableRam[s_ff.tableWriteAddress] <= regWrData;
    end
  end

  always_comb begin
    nxt_s = s_ff;
    if (regWr) begin
      unique case (regAddr)
        mos_pkg::OFS_STEP_OUTPUT_SOURCE_SELECT: begin
          nxt_s.stepSourceSelect = regWrData[1:0];
        end
        mos_pkg::OFS_ANALOG_OUT0_DIRECT_VALUE: begin
          nxt_s.analog0DirectLevel = regWrData;
        end
        mos_pkg::OFS_ANALOG_OUT1_DIRECT_VALUE: begin
          nxt_s.analog1DirectLevel = regWrData;
        end
        mos_pkg::OFS_ANALOG_OUT2_DIRECT_VALUE: begin
          nxt_s.analog2DirectLevel = regWrData;
        end
        mos_pkg::OFS_CURRENT_LEVEL_DIRECT_VALUE: begin
          nxt_s.currentLevelDirectBits = regWrData[1:0];
        end
        mos_pkg::OFS_OUTPUT_SOURCE_CONFIG: begin
          nxt_s.conf = regWrData[5:0];
        end
        mos_pkg::OFS_TABLE_WRITE_ADDRESS: begin
          nxt_s.tableWriteAddress = regWrData[6:0];
        end
        mos_pkg::OFS_TABLE_END: begin
          nxt_s.tableEnd = regWrData[6:0];
        end
        default: begin
        end
      endcase
    end
    nxt_s.readData = mos_pkg::RST_BYTE;
    if (regRd) begin
      unique case (regAddr)
        mos_pkg::OFS_STEP_OUTPUT_SOURCE_SELECT:
          nxt_s.readData = {6'h00, s_ff.stepSourceSelect};
        mos_pkg::OFS_ANALOG_OUT0_DIRECT_VALUE:
          nxt_s.readData = s_ff.analog0DirectLevel;
        mos_pkg::OFS_ANALOG_OUT1_DIRECT_VALUE:
          nxt_s.readData = s_ff.analog1DirectLevel;
        mos_pkg::OFS_ANALOG_OUT2_DIRECT_VALUE:
          nxt_s.readData = s_ff.analog2DirectLevel;
        mos_pkg::OFS_CURRENT_LEVEL_DIRECT_VALUE:
          nxt_s.readData = {6'h00, s_ff.currentLevelDirectBits};
        mos_pkg::OFS_OUTPUT_SOURCE_CONFIG:
          nxt_s.readData = {2'h0, s_ff.conf};
        mos_pkg::OFS_TABLE_WRITE_ADDRESS:
          nxt_s.readData = {1'h0, s_ff.tableWriteAddress};
        mos_pkg::OFS_TABLE_WRITE_DATA:
          nxt_s.readData = tableRam[s_ff.tableWriteAddress];
        mos_pkg::OFS_TABLE_END:
          nxt_s.readData = {1'h0, s_ff.tableEnd};
        mos_pkg::OFS_TABLE_POINTER_PHASE_A:
          nxt_s.readData = {1'h0, tablePointer[0]};
        mos_pkg::OFS_TABLE_POINTER_PHASE_B:
          nxt_s.readData = {1'h0, tablePointer[1]};
        mos_pkg::OFS_TABLE_POINTER_PHASE_C:
          nxt_s.readData = {1'h0, tablePointer[2]};
        default: nxt_s.readData = mos_pkg::RST_BYTE;
      endcase
    end
    // Analog channel 0.
    if (sources.sinestepActive) begin
      nxt_s.analog0 = sources.cosineWave;
    end else if (sources.microstepActive) begin
      nxt_s.analog0 = tableByte[0];
    end else begin
      nxt_s.analog0 = s_ff.conf.analog0DirectSelect ? s_ff.analog0DirectLevel
                                                    : tableByte[0];
    end
    // Analog channel 1.
    if (sources.sinestepActive) begin
      nxt_s.analog1 = sources.sineWave;
    end else if (sources.microstepActive) begin
      nxt_s.analog1 = tableByte[1];
    end else begin
      nxt_s.analog1 = s_ff.conf.analog1DirectSelect ? s_ff.analog1DirectLevel
                                                    : tableByte[1];
    end
    // Analog channel 2, velocity first, then table, then direct or current.
    if (s_ff.conf.velocityToAnalog2) begin
      nxt_s.analog2 = velocityLevel;
    end else if (sources.microstepActive && sources.threePhaseMotor) begin
      nxt_s.analog2 = tableByte[2];
    end else begin
      nxt_s.analog2 = s_ff.conf.analog2DirectSelect ? s_ff.analog2DirectLevel
                      : sources.currentControlLevel;
    end
    nxt_s.currentLevel = s_ff.conf.currentLevelDirectSelect
                         ? s_ff.currentLevelDirectBits
                         : sources.currentControlBits;
    if (s_ff.conf.velocityToStepOutputs) begin
      nxt_s.stepBus = velocityStep;
    end else if (s_ff.stepSourceSelect == mos_pkg::STO_SEQUENCER) begin
      nxt_s.stepBus = sources.sequencerSteps;
    end else begin
      nxt_s.stepBus = wordSlice(tableWord, s_ff.stepSourceSelect);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      s_ff.tableEnd <= mos_pkg::RST_TABLE_END;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign regRdData = s_ff.readData;
  assign analogOutZero = s_ff.analog0;
  assign analogOutOne = s_ff.analog1;
  assign analogOutTwo = s_ff.analog2;
  assign currentLevelLowPin = s_ff.currentLevel[0];
  assign currentLevelHighPin = s_ff.currentLevel[1];
  assign stepOutputBus = s_ff.stepBus;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic [23:0] velocityAbsRef;
  assign velocityAbsRef = actualVelocity[23] ? 24'(-actualVelocity)
                                             : actualVelocity;

  AST_DIRECT_ZERO: assert property (
    !sources.sinestepActive && !sources.microstepActive &&
    s_ff.conf.analog0DirectSelect |=>
    analogOutZero == $past(s_ff.analog0DirectLevel))
    else $error("Channel 0 does not show its direct value.");
  AST_MC_DIRECT: assert property (
    s_ff.conf.currentLevelDirectSelect |=>
    {currentLevelHighPin, currentLevelLowPin} ==
    $past(s_ff.currentLevelDirectBits))
    else $error("Current-level pins ignore the direct register.");
  AST_COSINE: assert property (
    sources.sinestepActive |=> analogOutZero == $past(sources.cosineWave))
    else $error("Channel 0 lost the cosine wave.");
  AST_TABLE_ZERO: assert property (
    !sources.sinestepActive && sources.microstepActive |=>
    analogOutZero == $past(tableRam[tablePointer[0]]))
    else $error("Channel 0 lost the phase 0 table byte.");
  AST_SINE: assert property (
    sources.sinestepActive |=> analogOutOne == $past(sources.sineWave))
    else $error("Channel 1 lost the sine wave.");
  AST_TABLE_TWO: assert property (
    !s_ff.conf.velocityToAnalog2 && sources.microstepActive &&
    sources.threePhaseMotor |=>
    analogOutTwo == $past(tableRam[tablePointer[2]]))
    else $error("Channel 2 lost the phase 2 table byte.");
  AST_CURRENT_TWO: assert property (
    !s_ff.conf.velocityToAnalog2 && !sources.microstepActive &&
    !s_ff.conf.analog2DirectSelect |=>
    analogOutTwo == $past(sources.currentControlLevel))
    else $error("Channel 2 lost the current control level.");
  AST_VEL_TWO: assert property (
    s_ff.conf.velocityToAnalog2 |=>
    analogOutTwo == $past(velocityAbsRef[12:5]))
    else $error("Channel 2 does not show velocity magnitude.");
  AST_MC_CURRENT: assert property (
    !s_ff.conf.currentLevelDirectSelect |=>
    {currentLevelHighPin, currentLevelLowPin} ==
    $past(sources.currentControlBits))
    else $error("Current-level pins ignore the current control.");
  AST_VEL_STEP: assert property (
    s_ff.conf.velocityToStepOutputs |=>
    stepOutputBus == $past(actualVelocity[12:3]))
    else $error("Step bus does not show velocity bits 12 to 3.");
  AST_STEP_HIGH: assert property (
    !s_ff.conf.velocityToStepOutputs && s_ff.stepSourceSelect == 2'h3 |=>
    stepOutputBus == $past({tableRam[tablePointer[2]],
                            tableRam[tablePointer[1]][7:6]}))
    else $error("Step bus does not show word bits 23 to 14.");
  AST_STEP_SEQ: assert property (
    !s_ff.conf.velocityToStepOutputs && s_ff.stepSourceSelect == 2'h0 |=>
    stepOutputBus == $past(sources.sequencerSteps))
    else $error("Step bus does not follow the sequencer.");
  AST_WORD_LOW: assert property (
    !s_ff.conf.velocityToStepOutputs && s_ff.stepSourceSelect == 2'h1 |=>
    stepOutputBus[7:0] == $past(tableRam[tablePointer[0]]))
    else $error("Phase 0 byte is not in the low word bits.");
  AST_POINTER_STEP: assert property (
    stepPulse && stepForward && !regWr &&
    tablePointer[0] < s_ff.tableEnd |=>
    tablePointer[0] == $past(tablePointer[0]) + 7'h01)
    else $error("Phase 0 pointer did not advance by one.");

  COV_SINESTEP: cover property (sources.sinestepActive);
  COV_VEL_STEP: cover property (s_ff.conf.velocityToStepOutputs);
  COV_POINTER_WRAP: cover property (
    stepPulse && stepForward && tablePointer[0] == s_ff.tableEnd);

endmodule

// *** verif/mos_drive_stage.sv ***
// Far-side model: converters and power stage latching the driven levels.
`timescale 1ns/100ps
module mos_drive_stage (
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Levels from the mux.
  input wire logic [7:0] levelZero,
  input wire logic [7:0] levelOne,
  input wire logic [7:0] levelTwo,
  input wire logic pinLow,
  input wire logic pinHigh,
  input wire logic [9:0] stepBus,
  // Latched view, as the converters and driver inputs hold it.
  output logic [35:0] sampled
);
  // The converters load on the rising edge, so a glitch between edges is
  // never seen, just as on the real parts.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sampled <= 36'h0;
    end else begin
      sampled <= {levelZero, levelOne, levelTwo, pinHigh, pinLow, stepBus};
    end
  end
endmodule

// *** verif/motor_output_source_mux_bench.sv ***
// Self-checking bench for the motor output source mux.
`timescale 1ns/100ps
module motor_output_source_mux_bench;
  logic clock;
  logic arst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  mos_pkg::mos_source_type src;
  logic [23:0] vel;
  logic stepPulse;
  logic stepForward;
  logic [7:0] aZero, aOne, aTwo;
  logic mcLow, mcHigh;
  logic [9:0] stoBus;
  logic [35:0] seen;
  int seed = 33;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] bA, bB, bC, d0, d1, d2;
  logic [23:0] word;

  mos_output_mux dut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sources(src), .actualVelocity(vel),
    .stepPulse(stepPulse), .stepForward(stepForward),
    .analogOutZero(aZero), .analogOutOne(aOne), .analogOutTwo(aTwo),
    .currentLevelLowPin(mcLow), .currentLevelHighPin(mcHigh),
    .stepOutputBus(stoBus));

  mos_drive_stage stage (.clock(clock), .arst_n(arst_n), .levelZero(aZero),
    .levelOne(aOne), .levelTwo(aTwo), .pinLow(mcLow), .pinHigh(mcHigh),
    .stepBus(stoBus), .sampled(seen));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [23:0] got,
                       input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    check("read data", regRdData, exp);
  endtask

  task automatic step(input logic fwd);
    @(posedge clock);
    stepPulse <= 1'b1;
    stepForward <= fwd;
    @(posedge clock);
    stepPulse <= 1'b0;
  endtask

  // Register and pointer writes reach the far side after a few edges.
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask

  function automatic logic [7:0] velAnalog(input logic [23:0] v);
    logic [23:0] m;
    m = v[23] ? -v : v;
    return m[12:5];
  endfunction

  function automatic logic [9:0] stoExp(input logic [1:0] sel,
      input logic [23:0] w, input logic [9:0] seq);
    case (sel)
      2'h1: return w[9:0];
      2'h2: return w[17:8];
      2'h3: return w[23:14];
      default: return seq;
    endcase
  endfunction

  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    src = '0;
    vel = 24'h0;
    stepPulse = 1'b0;
    stepForward = 1'b0;
    arst_n = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    // The table has no reset, so every byte gets a known value first.
    for (int a = 0; a < 128; a++) begin
      wr(8'hE0, a[7:0]);
      wr(8'hE1, 8'($random(seed)));
    end
    // Reset values, readback widths and an unmapped place.
    rd(8'h2D, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(8'h90 + i[7:0], 8'h00);
    end
    wr(8'h2D, 8'hFF);
    rd(8'h2D, 8'h03);
    wr(8'h93, 8'hFF);
    rd(8'h93, 8'h03);
    wr(8'h94, 8'hFF);
    rd(8'h94, 8'h3F);
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    $display("Test registers done");
    // Direct mode on all three analog channels and the current-level pins, random levels.
    for (int n = 0; n < 6; n++) begin
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      src.currentControlBits <= 2'($random(seed));
      src.currentControlLevel <= 8'($random(seed));
      wr(8'h94, 8'h0F);
      wr(8'h90, d0);
      wr(8'h91, d1);
      wr(8'h92, d2);
      wr(8'h93, {6'h0, d0[1:0]});
      settle();
      check("ch0 direct", seen[35:28], d0);
      check("ch1 direct", seen[27:20], d1);
      check("ch2 direct", seen[19:12], d2);
      check("pins direct", seen[11:10], d0[1:0]);
      wr(8'h94, 8'h00);
      settle();
      check("ch2 current", seen[19:12], src.currentControlLevel);
      check("pins current", seen[11:10], src.currentControlBits);
    end
    $display("Test direct done");
    // Table bytes at the three pointers, then one forward step.
    wr(8'hE0, 8'h03);
    wr(8'hE1, 8'h3C);
    wr(8'hE0, 8'h04);
    wr(8'hE1, 8'hC1);
    wr(8'hE0, 8'h28);
    wr(8'hE1, 8'h5A);
    wr(8'hE0, 8'h29);
    wr(8'hE1, 8'h96);
    wr(8'hE0, 8'h64);
    wr(8'hE1, 8'hE7);
    wr(8'hE0, 8'h65);
    wr(8'hE1, 8'h0B);
    wr(8'hE5, 8'h03);
    wr(8'hE6, 8'h28);
    wr(8'hE7, 8'h64);
    rd(8'hE6, 8'h28);
    rd(8'hE1, 8'h0B);
    src.sequencerSteps <= 10'($random(seed));
    for (int s = 0; s < 2; s++) begin
      bA = s ? 8'hC1 : 8'h3C;
      bB = s ? 8'h96 : 8'h5A;
      bC = s ? 8'h0B : 8'hE7;
      word = {bC, bB, bA};
      src.microstepActive <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        wr(8'h2D, c[7:0]);
        settle();
        check("step bus", seen[9:0],
              stoExp(c[1:0], word, src.sequencerSteps));
      end
      check("ch0 table", seen[35:28], bA);
      src.microstepActive <= 1'b1;
      src.threePhaseMotor <= 1'b1;
      wr(8'h94, 8'h07);
      settle();
      check("ch0 micro", seen[35:28], bA);
      check("ch1 micro", seen[27:20], bB);
      check("ch2 micro", seen[19:12], bC);
      src.threePhaseMotor <= 1'b0;
      settle();
      check("ch2 two phase", seen[19:12], d2);
      wr(8'h94, 8'h00);
      // One step only, so the later tests see the second set of bytes.
      if (s == 0) begin
        step(1'b1);
      end
    end
    rd(8'hE5, 8'h04);
    $display("Test table done");
    // Sinestep beats microstep on channels 0 and 1 only.
    src.sinestepActive <= 1'b1;
    src.cosineWave <= 8'($random(seed));
    src.sineWave <= 8'($random(seed));
    src.threePhaseMotor <= 1'b1;
    settle();
    check("ch0 cosine", seen[35:28], src.cosineWave);
    check("ch1 sine", seen[27:20], src.sineWave);
    check("ch2 no sine", seen[19:12], 8'h0B);
    $display("Test sinestep done");
    // Velocity overrides, negative edge cases among random ones.
    for (int n = 0; n < 6; n++) begin
      vel <= (n == 0) ? 24'hFFFFFF : (n == 1) ? 24'h800000
                                              : 24'($random(seed));
      wr(8'h2D, n[7:0]);
      wr(8'h94, 8'h30);
      settle();
      check("ch2 velocity", seen[19:12], velAnalog(vel));
      check("step velocity", seen[9:0], vel[12:3]);
      wr(8'h94, 8'h00);
      settle();
      check("step normal", seen[9:0], stoExp(n[1:0], 24'h0B96C1,
            src.sequencerSteps));
    end
    $display("Test velocity done");
    // A short table end makes every pointer wrap, forward and backward.
    wr(8'hE4, 8'h10);
    wr(8'hE5, 8'h10);
    step(1'b1);
    rd(8'hE5, 8'h00);
    rd(8'hE6, 8'h00);
    step(1'b0);
    rd(8'hE5, 8'h10);
    rd(8'hE7, 8'h10);
    rd(8'hE4, 8'h10);
    $display("Test pointer wrap done");
    report_and_stop();
  end
endmodule
